// *** mbi_host_port.v ***
// Host bus interface: address latch, strobe roles, byte steering, memory
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "mbi_map.vh"
module mbi_host_port #(
	parameter AW = 16,
	parameter MEM_WORDS_LOG2 = 8,
	parameter [15:0] SEL_BASE = 16'h0000
) (
	input wire aclk, // Clock
	input wire aresetn, // Synchronous reset, active low
	input wire [7:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output wire s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output wire s_axi_wready, // Write data ready
	output wire [1:0] s_axi_bresp, // Write response
	output wire s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [7:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output wire s_axi_arready, // Read address ready
	output wire [31:0] s_axi_rdata, // Read data
	output wire [1:0] s_axi_rresp, // Read response
	output wire s_axi_rvalid, // Read response valid
	input wire s_axi_rready, // Read response ready
	input wire [15:0] addr_data_port_i, // Address/data port pin level
	output reg [15:0] addr_data_port_o, // Address/data port drive value
	output reg [15:0] addr_data_port_oe, // Address/data port drive enable
	input wire [15:0] data_port_i, // Port D (high) and port C (low) pin level
	output reg [15:0] data_port_o, // Port D/C drive value
	output reg [15:0] data_port_oe, // Port D/C drive enable
	input wire rd_n, // Read strobe, active low
	input wire wr_n, // Write strobe, doubles as write low strobe
	input wire port_e_pin_zero, // Role-selected bus control
	input wire port_e_pin_one, // Address latch strobe, active high
	output reg [1:0] logic_bus_ctl, // Bus controls routed to logic input bus
	output reg [1:0] macrocell_fb_en // Feedback enable for port E macrocells 0 and 1
);
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_DRIVE = 3'b100;
	localparam integer ACC_CYC_I = `MBI_ACCESS_CYC;
	localparam [3:0] ACC_CYC = ACC_CYC_I[3:0];
	wire [31:0] cfg;
	wire [15:0] ad_s;
	wire [15:0] dp_s;
	wire [3:0] ctl_s;
	wire [3:0] ctl_a;
	wire mux_mode;
	wire wide;
	wire latch_en;
	wire [2:0] role;
	wire rd_act;
	wire wr_act;
	wire ale;
	wire pe0;
	reg [15:0] addr_lat_reg;
	reg [15:0] addr_use;
	reg selected;
	reg hi_en;
	reg lo_en;
	reg swap;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [3:0] cnt_reg;
	reg [3:0] cnt_next;
	reg wr_prev_reg;
	reg [15:0] last_reg;
	reg [15:0] wdata;
	reg [15:0] rdata;
	reg [7:0] mem_even [0:(1<<MEM_WORDS_LOG2)-1];
	reg [7:0] mem_odd [0:(1<<MEM_WORDS_LOG2)-1];
	wire [MEM_WORDS_LOG2-1:0] widx;
	assign widx = addr_use[MEM_WORDS_LOG2:1];
	mbi_axil u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.cfg_reg(cfg),
		.stat_in({8'h00, wr_prev_reg, selected, state_reg, role, last_reg}),
		.last_in({16'h0000, addr_use})
	);
	mbi_sync #(.W(16)) u_sync_ad (
		.aclk(aclk),
		.aresetn(aresetn),
		.d_in(addr_data_port_i),
		.q_out(ad_s)
	);
	mbi_sync #(.W(16)) u_sync_dp (
		.aclk(aclk),
		.aresetn(aresetn),
		.d_in(data_port_i),
		.q_out(dp_s)
	);
	mbi_sync #(.W(4)) u_sync_ctl (
		.aclk(aclk),
		.aresetn(aresetn),
		.d_in({port_e_pin_one, ~port_e_pin_zero, ~wr_n, ~rd_n}),
		.q_out(ctl_a)
	);
	// Active-low pins cross inverted so the flops' reset value reads as idle
	assign ctl_s = {ctl_a[3], ~ctl_a[2:0]};
	assign mux_mode = cfg[`MBI_CFG_MUX_BIT];
	assign wide = cfg[`MBI_CFG_WIDE_BIT];
	assign latch_en = cfg[`MBI_CFG_LATCH_BIT];
	assign role = cfg[`MBI_CFG_ROLE_MSB:`MBI_CFG_ROLE_LSB];
	assign ale = ctl_s[3];
	assign pe0 = ctl_s[2];
	// Program store enable is a second read strobe (program fetch)
	assign rd_act = !ctl_s[0] || (role == `MBI_ROLE_PROGRAM_STORE_ENABLE && !pe0);
	assign wr_act = !ctl_s[1] || (role == `MBI_ROLE_WRH && !pe0);
	// Transparent while strobe high, holds afterwards
	always @(posedge aclk)
	begin
		if (!aresetn)
			addr_lat_reg <= 16'h0000;
		else if (ale)
			addr_lat_reg <= ad_s;
	end
	always @*
	begin
		if (mux_mode)
			addr_use = ale ? ad_s : addr_lat_reg;
		else if (latch_en)
			addr_use = ale ? ad_s : addr_lat_reg;
		else
			addr_use = ad_s;
		selected = (addr_use[AW-1:MEM_WORDS_LOG2+1] ==
			SEL_BASE[AW-1:MEM_WORDS_LOG2+1]);
	end
	// Lane enables and byte placement per role; swap puts even on high lane
	always @*
	begin
		hi_en = 1'b0;
		lo_en = 1'b0;
		swap = 1'b0;
		if (!wide)
			lo_en = 1'b1;
		else
		begin
			case (role)
				`MBI_ROLE_BHE, `MBI_ROLE_PROGRAM_STORE_ENABLE:
				begin
					hi_en = !pe0;
					lo_en = !addr_use[0];
				end
				`MBI_ROLE_WRH:
				begin
					hi_en = !pe0;
					lo_en = !ctl_s[1];
				end
				`MBI_ROLE_UDS:
				begin
					swap = 1'b1;
					hi_en = !pe0;
					lo_en = !ctl_s[0];
				end
				`MBI_ROLE_SIZ:
				begin
					swap = 1'b1;
					hi_en = !addr_use[0];
					lo_en = !pe0 || addr_use[0];
				end
				default:
				begin
					hi_en = 1'b0;
					lo_en = 1'b0;
				end
			endcase
		end
	end
	always @*
	begin
		wdata = mux_mode ? ad_s : dp_s;
		if (!wide)
			rdata = {8'h00, addr_use[0] ? mem_odd[widx] : mem_even[widx]};
		else if (swap)
			rdata = {mem_even[widx], mem_odd[widx]};
		else
			rdata = {mem_odd[widx], mem_even[widx]};
	end
	always @*
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			ST_IDLE:
				if (rd_act && selected && !ale)
				begin
					state_next = ST_WAIT;
					cnt_next = ACC_CYC;
				end
			ST_WAIT:
				if (!rd_act || !selected)
					state_next = ST_IDLE;
				else if (cnt_reg <= 4'd1)
					state_next = ST_DRIVE;
				else
					cnt_next = cnt_reg - 4'd1;
			ST_DRIVE:
				if (!rd_act || !selected)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			wr_prev_reg <= 1'b0;
			last_reg <= 16'h0000;
			addr_data_port_o <= 16'h0000;
			addr_data_port_oe <= 16'h0000;
			data_port_o <= 16'h0000;
			data_port_oe <= 16'h0000;
			logic_bus_ctl <= 2'b00;
			macrocell_fb_en <= 2'b11;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			wr_prev_reg <= wr_act;
			// Pins 0 and 1 always serve as bus controls here
			macrocell_fb_en <= 2'b00;
			logic_bus_ctl <= {ale, pe0};
			addr_data_port_oe <= 16'h0000;
			data_port_oe <= 16'h0000;
			if (state_next == ST_DRIVE)
			begin
				if (mux_mode)
				begin
					addr_data_port_o <= rdata;
					addr_data_port_oe <= {{8{hi_en}}, {8{lo_en}}};
				end
				else
				begin
					data_port_o <= rdata;
					data_port_oe <= {{8{hi_en}}, {8{lo_en}}};
				end
			end
			// Written every strobe cycle while the address is selected; the value at release is what stays
			if (wr_act && selected)
				last_reg <= wdata;
		end
	end
	always @(posedge aclk)
	begin
		// Lane strobes vanish at release, so write through while they stand
		if (aresetn && wr_act && selected)
		begin
			if (!wide)
			begin
				if (addr_use[0])
					mem_odd[widx] <= wdata[7:0];
				else
					mem_even[widx] <= wdata[7:0];
			end
			else
			begin
				if (hi_en)
				begin
					if (swap)
						mem_even[widx] <= wdata[15:8];
					else
						mem_odd[widx] <= wdata[15:8];
				end
				if (lo_en)
				begin
					if (swap)
						mem_odd[widx] <= wdata[7:0];
					else
						mem_even[widx] <= wdata[7:0];
				end
			end
		end
	end
endmodule // mbi_host_port
`default_nettype wire

// *** mbi_map.vh ***
// Constants for the host bus interface with byte steering
`ifndef MBI_MAP_VH
`define MBI_MAP_VH
// Register byte offsets on the configuration bus
`define MBI_CFG_OFS 8'h00
`define MBI_STAT_OFS 8'h04
`define MBI_LAST_OFS 8'h08
// Configuration field positions
`define MBI_CFG_MUX_BIT 0
`define MBI_CFG_WIDE_BIT 1
`define MBI_CFG_LATCH_BIT 2
`define MBI_CFG_ROLE_LSB 4
`define MBI_CFG_ROLE_MSB 6
`define MBI_CFG_RESET 32'h00000003
// Roles of port_e_pin_zero
`define MBI_ROLE_BHE 3'h0
`define MBI_ROLE_PROGRAM_STORE_ENABLE 3'h1
`define MBI_ROLE_WRH 3'h2
`define MBI_ROLE_UDS 3'h3
`define MBI_ROLE_SIZ 3'h4
// Access time before read data is driven
`define MBI_ACCESS_NS 20
`define MBI_CLK_NS 4
`define MBI_ACCESS_CYC ((`MBI_ACCESS_NS + `MBI_CLK_NS - 1) / `MBI_CLK_NS)
// AXI responses
`define MBI_RESP_OKAY 2'h0
`define MBI_RESP_DECERR 2'h3
`endif

// *** mbi_sync.v ***
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
`default_nettype none
module mbi_sync #(
	parameter W = 1
) (
	input wire aclk, // Clock
	input wire aresetn, // Synchronous reset, active low
	input wire [W-1:0] d_in, // Asynchronous input
	output reg [W-1:0] q_out // Synchronised output
);
	reg [W-1:0] meta_reg;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_reg <= {W{1'b0}};
			q_out <= {W{1'b0}};
		end
		else
		begin
			meta_reg <= d_in;
			q_out <= meta_reg;
		end
	end
endmodule // mbi_sync
`default_nettype wire

// *** mbi_axil.v ***
// AXI4-Lite slave holding the bus interface configuration and status
`timescale 1ns/100ps
`default_nettype none
`include "mbi_map.vh"
module mbi_axil (
	input wire aclk, // Clock
	input wire aresetn, // Synchronous reset, active low
	input wire [7:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output wire s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output wire s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [7:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output wire s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read response valid
	input wire s_axi_rready, // Read response ready
	output reg [31:0] cfg_reg, // Configuration word
	input wire [31:0] stat_in, // Live status word
	input wire [31:0] last_in // Last host access word
);
	reg aw_got_reg;
	reg w_got_reg;
	reg [7:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	wire do_write;
	integer i;
	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_got_reg && w_got_reg;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h00000000;
			cfg_reg <= `MBI_CFG_RESET;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_reg[7:2] == `MBI_CFG_OFS >> 2)
				begin
					s_axi_bresp <= `MBI_RESP_OKAY;
					for (i = 0; i < 4; i = i + 1)
						if (w_strb_reg[i])
							cfg_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
				end
				else if (aw_addr_reg[7:2] == `MBI_STAT_OFS >> 2 ||
					aw_addr_reg[7:2] == `MBI_LAST_OFS >> 2)
					s_axi_bresp <= `MBI_RESP_OKAY;
				else
					s_axi_bresp <= `MBI_RESP_DECERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `MBI_RESP_OKAY;
				case (s_axi_araddr[7:2])
					`MBI_CFG_OFS >> 2: s_axi_rdata <= cfg_reg;
					`MBI_STAT_OFS >> 2: s_axi_rdata <= stat_in;
					`MBI_LAST_OFS >> 2: s_axi_rdata <= last_in;
					default:
					begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `MBI_RESP_DECERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // mbi_axil
`default_nettype wire

// *** mbi_props.sv ***
// Checker for the host port pins and the register bus answers
`timescale 1ns/100ps
`default_nettype none
module mbi_props (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic rd_n, // Read strobe
	input wire logic port_e_pin_zero, // Role pin
	input wire logic port_e_pin_one, // Latch strobe
	input wire logic [15:0] addr_data_port_oe, // Port enable
	input wire logic [15:0] data_port_oe, // Data enable
	input wire logic [1:0] logic_bus_ctl, // Logic bus controls
	input wire logic [1:0] macrocell_fb_en, // Feedback enables
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic s_axi_rvalid // R valid
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_idle;
		(rd_n && port_e_pin_zero) [*5];
	endsequence
	sequence s_latching;
		port_e_pin_one [*5];
	endsequence
	a_fb_cut: assert property (aresetn && $past(aresetn) |-> macrocell_fb_en == 2'h0)
		else $error("feedback not cut");
	a_ctl_route: assert property ($stable({port_e_pin_one, port_e_pin_zero}) [*5]
		|-> logic_bus_ctl == {port_e_pin_one, port_e_pin_zero})
		else $error("controls not on logic bus");
	a_access_time: assert property ($rose(|addr_data_port_oe) |-> !$past(rd_n, 6))
		else $error("port driven before access time");
	a_idle_quiet: assert property (s_idle |=> addr_data_port_oe == 16'h0000
		&& data_port_oe == 16'h0000)
		else $error("port driven while idle");
	a_one_port: assert property (addr_data_port_oe == 16'h0000 || data_port_oe == 16'h0000)
		else $error("both ports driven");
	a_latch_quiet: assert property (s_latching |-> addr_data_port_oe == 16'h0000)
		else $error("port driven in address phase");
	a_b_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
endmodule // mbi_props
`default_nettype wire

// *** mbi_host_model.sv ***
// Host controller model for the multiplexed address/data bus
`timescale 1ns/100ps
`default_nettype none
module mbi_host_model (
	input wire logic aclk, // Clock
	input wire logic [15:0] addr_data_port_o, // Device drive
	input wire logic [15:0] addr_data_port_oe, // Device enable
	output logic [15:0] addr_data_port_i, // Bus level
	output logic rd_n = 1'b1, // Read strobe
	output logic wr_n = 1'b1, // Write strobe
	output logic port_e_pin_zero = 1'b1, // Role pin
	output logic port_e_pin_one = 1'b0 // Latch strobe
);
	logic [15:0] hv = 16'h0000;
	// No pull on the bus, so a line the device does not enable shows the host's value hv
	assign addr_data_port_i = (addr_data_port_oe & addr_data_port_o)
		| (~addr_data_port_oe & hv);
	task automatic put(input logic [15:0] v, input logic [3:0] c);
		@(posedge aclk);
		hv <= v;
		{port_e_pin_one, rd_n, wr_n, port_e_pin_zero} <= c;
		repeat (5) @(posedge aclk);
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] s);
		put(a, 4'hF);
		put(a, 4'h7);
		put(d, {2'h1, s});
		// Data held past the strobe release; the write commits while the strobe stands
		put(d, 4'h7);
		put(~d, 4'h7);
	endtask
	task automatic rd(input logic [15:0] a, input logic e, output logic [15:0] d,
		output logic [15:0] m);
		int n;
		put(a, 4'hF);
		put(a, 4'h7);
		@(posedge aclk);
		hv <= ~a;
		{port_e_pin_one, rd_n, wr_n, port_e_pin_zero} <= {3'h1, e};
		n = 0;
		while (addr_data_port_oe === 16'h0000 && n < 40)
		begin
			@(posedge aclk);
			n++;
		end
		@(posedge aclk);
		d = addr_data_port_o & addr_data_port_oe;
		m = addr_data_port_oe;
		put(~a, 4'h7);
	endtask
endmodule // mbi_host_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the host bus interface
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, w) begin check_count++; if ((g) !== (w)) begin bad_count++; \
	$display("BAD %0t got %h want %h", $time, g, w); end end
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, macrocell_fb_en, rr;
	logic [31:0] s_axi_rdata, rv;
	logic [15:0] addr_data_port_i, addr_data_port_o, addr_data_port_oe, d, m;
	logic rd_n, wr_n, port_e_pin_zero, port_e_pin_one;
	logic [15:0] dpi = 16'h0000, dpo, dpoe;
	logic [1:0] lbc;
	int bad_count = 0;
	int check_count = 0;
	always #2 aclk = ~aclk;
	mbi_host_port i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .addr_data_port_i, .addr_data_port_o,
		.addr_data_port_oe, .data_port_i(dpi), .data_port_o(dpo), .data_port_oe(dpoe), .rd_n,
		.wr_n, .port_e_pin_zero, .port_e_pin_one, .logic_bus_ctl(lbc), .macrocell_fb_en);
	mbi_host_model i_host (.aclk, .addr_data_port_o, .addr_data_port_oe, .addr_data_port_i,
		.rd_n, .wr_n, .port_e_pin_zero, .port_e_pin_one);
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, 2'h0)
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic hrd(input logic [15:0] a, input logic e, input logic [15:0] wd,
		input logic [15:0] wm);
		i_host.rd(a, e, d, m);
		`CHK(d, wd)
		`CHK(m, wm)
	endtask
	task automatic test_done;
		$display("checks %0d bad %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#60000;
		bad_count++;
		test_done;
	end
	initial
	begin
		repeat (4) @(posedge aclk);
		`CHK(macrocell_fb_en, 2'h3)
		aresetn <= 1'b1;
		axr(8'h00);
		`CHK(rv, 32'h00000003)
		`CHK(lbc, 2'h1)
		`CHK(macrocell_fb_en, 2'h0)
		axr(8'h0C);
		`CHK(rr, 2'h3)
		i_host.wr(16'h0020, 16'hB7C4, 2'h0);
		hrd(16'h0020, 1'b0, 16'hB7C4, 16'hFFFF);
		i_host.wr(16'h0020, 16'h0011, 2'h1);
		i_host.wr(16'h0021, 16'h5A00, 2'h0);
		hrd(16'h0021, 1'b0, 16'h5A00, 16'hFF00);
		hrd(16'h0020, 1'b0, 16'h5A11, 16'hFFFF);
		// Outside the selected window nothing may answer
		hrd(16'h8000, 1'b0, 16'h0000, 16'h0000);
		axw(8'h00, 32'h00000001);
		hrd(16'h0020, 1'b1, 16'h0011, 16'h00FF);
		hrd(16'h0021, 1'b0, 16'h005A, 16'h00FF);
		for (int r = 0; r < 5; r++)
		begin
			axw(8'h00, 32'h00000003 | (r << 4));
			axr(8'h00);
			`CHK(rv, 32'h00000003 | (r << 4))
		end
		hrd(16'h0020, 1'b0, 16'h115A, 16'hFFFF);
		hrd(16'h0021, 1'b1, 16'h005A, 16'h00FF);
		axw(8'h00, 32'h00000023);
		i_host.wr(16'h0020, 16'hC300, 2'h2);
		axw(8'h00, 32'h00000003);
		hrd(16'h0020, 1'b0, 16'hC311, 16'hFFFF);
		axw(8'h00, 32'h00000033);
		hrd(16'h0020, 1'b0, 16'h11C3, 16'hFFFF);
		hrd(16'h0020, 1'b1, 16'h00C3, 16'h00FF);
		// Non-multiplexed: address on the address/data port, data on ports D and C
		dpi <= 16'hA55A;
		axw(8'h00, 32'h00000002);
		i_host.put(16'h0022, 4'h4);
		i_host.put(16'h0022, 4'h7);
		i_host.put(16'h0022, 4'h2);
		i_host.put(16'h0022, 4'h2);
		`CHK(dpo & dpoe, 16'hA55A)
		`CHK(dpoe, 16'hFFFF)
		`CHK(addr_data_port_oe, 16'h0000)
		i_host.put(16'h0022, 4'h7);
		`CHK(dpoe, 16'h0000)
		// Latched: the address caught by the strobe outlives the pins
		axw(8'h00, 32'h00000006);
		i_host.put(16'h0022, 4'hF);
		i_host.put(16'h8000, 4'h2);
		i_host.put(16'h8000, 4'h2);
		`CHK(dpo & dpoe, 16'hA55A)
		i_host.put(16'h8000, 4'h7);
		test_done;
	end
endmodule // tb_top
bind mbi_host_port mbi_props i_props (.aclk, .aresetn, .rd_n, .port_e_pin_zero,
	.port_e_pin_one, .addr_data_port_oe, .data_port_oe, .logic_bus_ctl, .macrocell_fb_en,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire
